/* core/pecs_pkg.sv */
package pecs_pkg;
    // event numbers and unit masks
    localparam logic [7:0] EVT_CORE_REJECT = 8'h31;
    localparam logic [7:0] EVT_UNHALTED = 8'h3C;
    localparam logic [7:0] EVT_IFETCH = 8'h80;
    localparam logic [7:0] EVT_OFFCORE = 8'hB7;
    localparam logic [7:0] UMASK_00 = 8'h00;
    localparam logic [7:0] UMASK_01 = 8'h01;
    localparam logic [7:0] UMASK_02 = 8'h02;
    localparam logic [7:0] UMASK_03 = 8'h03;
    // default counter width, number of programmable counters and reference divider
    localparam int CNT_WIDTH_DEF = 48;
    localparam int NUM_PROG_DEF = 2;
    localparam int REF_DIV_DEF = 1;
    // reject cause vector positions
    localparam int RJ_L2Q_FULL = 0;
    localparam int RJ_XQ_BYPASS = 1;
    localparam int RJ_FAIRNESS = 2;
    localparam int RJ_EVICT_CONFLICT = 3;
    localparam int RJ_WIDTH = 4;
endpackage : pecs_pkg

/* core/pecs_qualify.sv */
`timescale 1ns/10ps
// one programmable counter: matches event number and unit mask to an occurrence
module pecs_qualify
    import pecs_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_WIDTH_DEF
) (
    input wire logic clock, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [7:0] evt_sel, // configured event number
    input wire logic [7:0] umask, // configured unit mask
    input wire logic reject_pulse, // one qualifying queue reject this cycle
    input wire logic unhalted, // core not halted this cycle
    input wire logic ref_tick, // reference tick while unhalted
    input wire logic fetch_hit, // fetch served from icache
    input wire logic fetch_miss, // new fetch miss (first cycle only)
    input wire logic offcore_a, // qualified offcore response a
    input wire logic offcore_b, // qualified offcore response b
    output logic [CNT_WIDTH-1:0] count // counter value
);
    typedef struct packed {
        logic [CNT_WIDTH-1:0] cnt;
    } pecs_q_state_t;

    pecs_q_state_t st_reg;
    pecs_q_state_t st_next;
    logic hit;

    // event selection decode; unrecognised pairs never count
    always_comb begin
        hit = 1'b0;
        case (evt_sel)
            EVT_CORE_REJECT: hit = (umask == UMASK_00) && reject_pulse;
            EVT_UNHALTED: begin
                if (umask == UMASK_00) hit = unhalted;
                else if (umask == UMASK_01) hit = ref_tick;
            end
            EVT_IFETCH: begin
                if (umask == UMASK_01) hit = fetch_hit;
                else if (umask == UMASK_02) hit = fetch_miss;
                else if (umask == UMASK_03) hit = fetch_hit | fetch_miss;
            end
            EVT_OFFCORE: begin
                if (umask == UMASK_01) hit = offcore_a;
                else if (umask == UMASK_02) hit = offcore_b;
            end
            default: hit = 1'b0;
        endcase
    end

    // next counter value; wraps silently, no overflow flag is kept anywhere
    always_comb begin
        st_next = st_reg;
        if (hit) st_next.cnt = st_reg.cnt + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign count = st_reg.cnt;

    chk_sel_unknown: assert property (@(posedge clock) disable iff (!rst_n)
        (evt_sel == 8'h00) |=> (count == $past(count)))
        else $error("unrecognised event advanced the counter");
endmodule : pecs_qualify

/* core/pecs_top.sv */
// Contract
// - Event 31H mask 0 counts demand and first-level prefetch requests the shared queue rejects as full.
// - That event also counts requests turned away on bypass because the external queue was full.
// - Dropped second-level prefetcher requests never add to the reject count.
// - Rejects made for fairness toward the other core are counted even with free entries.
// - Dirty evictions rejected for an address conflict with a pending request or snoop are counted.
// - Event 3CH mask 0 counts each core cycle the core is not halted by the halt instruction.
// - Fixed counter one counts the same unhalted core-cycle condition.
// - Event 3CH mask 1 counts unhalted reference cycles at a rate independent of core frequency.
// - Fixed counter two counts the same unhalted reference-cycle condition.
// - Event 80H mask 1 counts fetches served from the instruction cache.
// - Event 80H mask 2 counts each fetch miss or memory-request fetch once, uncacheable included.
// - Event 80H mask 3 counts every fetch, uncacheable included.
// - Offcore events mask 1 and 2 count only as qualified by their own qualifier register.
// - The external queue sits between the shared queue and the outbound link, shared by a core pair.
`timescale 1ns/10ps
module pecs_top
    import pecs_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_WIDTH_DEF,
    parameter int NUM_PROG = NUM_PROG_DEF,
    parameter int QUAL_WIDTH = 16
) (
    input wire logic clock, // core clock, 20 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [NUM_PROG*8-1:0] evt_sel, // event number per counter
    input wire logic [NUM_PROG*8-1:0] umask, // unit mask per counter
    input wire logic req_valid, // core request presented to shared queue
    input wire logic req_is_l2_prefetch, // request is a second-level prefetch
    input wire logic req_is_dirty_evict, // request is a dirty first-level eviction
    input wire logic req_bypass_xq, // request would go straight to external queue
    input wire logic l2q_full, // shared queue full or nearly full
    input wire logic xq_full, // external queue full or nearly full
    input wire logic fair_block, // fairness arbiter blocks this core
    input wire logic addr_conflict, // eviction hits pending request or snoop
    input wire logic halted, // core halted by halt instruction
    input wire logic ref_clk_tick, // reference-rate tick, max-frequency equivalent
    input wire logic fetch_valid, // instruction fetch this cycle
    input wire logic fetch_hit, // fetch served from icache
    input wire logic fetch_miss_pending, // fetch miss outstanding (level)
    input wire logic ofc_resp_valid, // offcore response seen
    input wire logic [QUAL_WIDTH-1:0] ofc_resp_attr, // request type and response bits
    input wire logic [QUAL_WIDTH-1:0] ofc_qual_a, // offcore qualifier register a
    input wire logic [QUAL_WIDTH-1:0] ofc_qual_b, // offcore qualifier register b
    output logic req_reject, // request rejected in the previous cycle, registered
    output logic [NUM_PROG*CNT_WIDTH-1:0] prog_count, // programmable counters
    output logic [CNT_WIDTH-1:0] fixed_core_count, // fixed counter one
    output logic [CNT_WIDTH-1:0] fixed_ref_count // fixed counter two
);
    if (NUM_PROG < 1 || CNT_WIDTH < 2 || QUAL_WIDTH < 1) begin : g_bad
        $error("pecs_top: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic reject;
        logic reject_cnt;
        logic unhalted;
        logic ref_tick;
        logic fetch_hit;
        logic fetch_miss_new;
        logic miss_seen;
        logic ofc_a;
        logic ofc_b;
        logic [CNT_WIDTH-1:0] fix_core;
        logic [CNT_WIDTH-1:0] fix_ref;
    } pecs_state_t;

    pecs_state_t st_reg;
    pecs_state_t st_next;
    logic [RJ_WIDTH-1:0] rj_cause;

    // offcore match: any attribute bit that is also set in the qualifier
    function automatic logic ofc_match(input logic [QUAL_WIDTH-1:0] attr,
                                       input logic [QUAL_WIDTH-1:0] qual);
        ofc_match = |(attr & qual);
    endfunction : ofc_match

    ////////////////////////////////////////////////////////////////////////////
    // reject causes at the shared queue; bypass covers the external queue
    // behind it, which holds second-level misses for both cores
    always_comb begin
        rj_cause = '0;
        rj_cause[RJ_L2Q_FULL] = l2q_full;
        rj_cause[RJ_XQ_BYPASS] = req_bypass_xq && xq_full;
        rj_cause[RJ_FAIRNESS] = fair_block;
        rj_cause[RJ_EVICT_CONFLICT] = req_is_dirty_evict && addr_conflict;
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.reject = req_valid && (|rj_cause);
        // dropped second-level prefetches are not core rejects
        st_next.reject_cnt = req_valid && !req_is_l2_prefetch && (|rj_cause);
        st_next.unhalted = !halted;
        st_next.ref_tick = !halted && ref_clk_tick;
        st_next.fetch_hit = fetch_valid && fetch_hit;
        // edge of the pending level so a long miss counts once
        st_next.fetch_miss_new = fetch_miss_pending && !st_reg.miss_seen;
        st_next.miss_seen = fetch_miss_pending;
        st_next.ofc_a = ofc_resp_valid && ofc_match(ofc_resp_attr, ofc_qual_a);
        st_next.ofc_b = ofc_resp_valid && ofc_match(ofc_resp_attr, ofc_qual_b);
        if (!halted) st_next.fix_core = st_reg.fix_core + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        if (!halted && ref_clk_tick) begin
            st_next.fix_ref = st_reg.fix_ref + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign req_reject = st_reg.reject;
    assign fixed_core_count = st_reg.fix_core;
    assign fixed_ref_count = st_reg.fix_ref;

    ////////////////////////////////////////////////////////////////////////////
    // programmable counters, each a registered count
    for (genvar i = 0; i < NUM_PROG; i++) begin : g_prog
        pecs_qualify #(
            .CNT_WIDTH(CNT_WIDTH)
        ) u_qual (
            .clock(clock),
            .rst_n(rst_n),
            .evt_sel(evt_sel[i*8 +: 8]),
            .umask(umask[i*8 +: 8]),
            .reject_pulse(st_reg.reject_cnt),
            .unhalted(st_reg.unhalted),
            .ref_tick(st_reg.ref_tick),
            .fetch_hit(st_reg.fetch_hit),
            .fetch_miss(st_reg.fetch_miss_new),
            .offcore_a(st_reg.ofc_a),
            .offcore_b(st_reg.ofc_b),
            .count(prog_count[i*CNT_WIDTH +: CNT_WIDTH])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_reject_fair: assert property (@(posedge clock) disable iff (!rst_n)
        (req_valid && !req_is_l2_prefetch && fair_block) |=> st_reg.reject_cnt)
        else $error("fairness reject not counted");
    chk_reject_l2q: assert property (@(posedge clock) disable iff (!rst_n)
        (req_valid && !req_is_l2_prefetch && l2q_full) |=> st_reg.reject_cnt)
        else $error("full queue reject not counted");
    chk_reject_bypass: assert property (@(posedge clock) disable iff (!rst_n)
        (req_valid && req_bypass_xq && xq_full) |=> req_reject)
        else $error("bypass reject missing");
    chk_drop_prefetch: assert property (@(posedge clock) disable iff (!rst_n)
        (req_is_l2_prefetch) |=> !st_reg.reject_cnt)
        else $error("dropped prefetch counted");
    chk_evict_conflict: assert property (@(posedge clock) disable iff (!rst_n)
        (req_valid && !req_is_l2_prefetch && req_is_dirty_evict && addr_conflict)
        |=> st_reg.reject_cnt)
        else $error("conflicting eviction not counted");
    chk_fixed_core: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (st_reg.unhalted && $past(rst_n)) |-> (fixed_core_count != $past(fixed_core_count)))
        else $error("fixed core counter stalled while unhalted");
    chk_fixed_halt: assert property (@(posedge clock) disable iff (!rst_n)
        halted |=> (fixed_core_count == $past(fixed_core_count)))
        else $error("fixed core counter moved while halted");
    chk_fixed_ref: assert property (@(posedge clock) disable iff (!rst_n)
        (!halted && ref_clk_tick) |=> (fixed_ref_count == $past(fixed_ref_count) + 1'b1))
        else $error("fixed reference counter missed a tick");
    chk_miss_once: assert property (@(posedge clock) disable iff (!rst_n)
        st_reg.fetch_miss_new |=> !st_reg.fetch_miss_new)
        else $error("outstanding miss counted twice");
    chk_ref_halt: assert property (@(posedge clock) disable iff (!rst_n)
        halted |=> !st_reg.ref_tick)
        else $error("reference tick while halted");
endmodule : pecs_top

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import pecs_pkg::*;
    // narrow counters keep the deltas readable; wrap is not exercised here
    localparam int CW = 16;
    logic clock, rst_n, req_valid, req_is_l2_prefetch, req_is_dirty_evict, req_bypass_xq;
    logic l2q_full, xq_full, fair_block, addr_conflict, halted, ref_clk_tick;
    logic fetch_valid, fetch_hit, fetch_miss_pending, ofc_resp_valid, req_reject;
    logic [15:0] evt_sel, umask, ofc_resp_attr, ofc_qual_a, ofc_qual_b;
    logic [2*CW-1:0] prog_count;
    logic [CW-1:0] fixed_core_count, fixed_ref_count, b0, b1, bc, br;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int rej_seen = 0;
    int rej_base = 0;
    pecs_top #(.CNT_WIDTH(CW), .NUM_PROG(2), .QUAL_WIDTH(16)) u_dut (
        .clock(clock), .rst_n(rst_n), .evt_sel(evt_sel), .umask(umask),
        .req_valid(req_valid), .req_is_l2_prefetch(req_is_l2_prefetch),
        .req_is_dirty_evict(req_is_dirty_evict), .req_bypass_xq(req_bypass_xq),
        .l2q_full(l2q_full), .xq_full(xq_full), .fair_block(fair_block),
        .addr_conflict(addr_conflict), .halted(halted), .ref_clk_tick(ref_clk_tick),
        .fetch_valid(fetch_valid), .fetch_hit(fetch_hit),
        .fetch_miss_pending(fetch_miss_pending), .ofc_resp_valid(ofc_resp_valid),
        .ofc_resp_attr(ofc_resp_attr), .ofc_qual_a(ofc_qual_a), .ofc_qual_b(ofc_qual_b),
        .req_reject(req_reject), .prog_count(prog_count),
        .fixed_core_count(fixed_core_count), .fixed_ref_count(fixed_ref_count));
    ////////////////////////////////////////////////////////////////////////////////
    // clock source
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // hang guard, far above the ~120 cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    // reject pulses last one cycle, so sample mid-cycle
    always @(negedge clock) begin
        if (req_reject === 1'b1)
            rej_seen = rej_seen + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp, input string what);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t %s got %0h want %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // quiet inputs; halted keeps the cycle counters still between scenarios
    task automatic idle();
        {req_valid, req_is_l2_prefetch, req_is_dirty_evict, req_bypass_xq} <= 4'h0;
        {l2q_full, xq_full, fair_block, addr_conflict} <= 4'h0;
        {halted, ref_clk_tick, fetch_valid, fetch_hit} <= 4'h8;
        {fetch_miss_pending, ofc_resp_valid} <= 2'h0;
        ofc_resp_attr <= 16'h0000;
    endtask : idle
    task automatic cfg(input logic [7:0] e0, u0, e1, u1);
        @(posedge clock);
        idle();
        evt_sel <= {e1, e0};
        umask <= {u1, u0};
        repeat (4) @(posedge clock);
        @(negedge clock);
        b0 = prog_count[CW-1:0];
        b1 = prog_count[2*CW-1:CW];
        bc = fixed_core_count;
        br = fixed_ref_count;
        rej_base = rej_seen;
    endtask : cfg
    // programmable counts land two cycles late, so wait past that
    task automatic deltas(input int x0, input int x1, input int xc, input int xr);
        @(posedge clock);
        idle();
        repeat (4) @(posedge clock);
        @(negedge clock);
        check(prog_count[CW-1:0] - b0, CW'(x0), "counter 0");
        check(prog_count[2*CW-1:CW] - b1, CW'(x1), "counter 1");
        check(fixed_core_count - bc, CW'(xc), "fixed core");
        check(fixed_ref_count - br, CW'(xr), "fixed ref");
    endtask : deltas
    task automatic zero_all();
        @(negedge clock);
        check(prog_count[CW-1:0] | prog_count[2*CW-1:CW] | fixed_core_count
            | fixed_ref_count | {15'h0000, req_reject}, 16'h0000, "reset");
    endtask : zero_all
    ////////////////////////////////////////////////////////////////////////////////
    // every reject cause back to back, plus prefetch and half-met causes
    task automatic t_reject();
        logic [7:0] vec [9] = '{8'h88, 8'h94, 8'h82, 8'hA1, 8'hC8, 8'h90, 8'h81, 8'h84, 8'h08};
        cfg(EVT_CORE_REJECT, UMASK_00, EVT_CORE_REJECT, UMASK_01);
        foreach (vec[i]) begin
            @(posedge clock);
            {req_valid, req_is_l2_prefetch, req_is_dirty_evict, req_bypass_xq,
                l2q_full, xq_full, fair_block, addr_conflict} <= vec[i];
        end
        deltas(4, 0, 0, 0);
        check(CW'(rej_seen - rej_base), 16'h0005, "reject pulses");
    endtask : t_reject
    // ten unhalted cycles, five ticks while running, two while halted
    task automatic t_unhalted();
        cfg(EVT_UNHALTED, UMASK_00, EVT_UNHALTED, UMASK_01);
        for (int i = 0; i < 14; i++) begin
            @(posedge clock);
            halted <= (i >= 10);
            ref_clk_tick <= i[0];
        end
        deltas(10, 5, 10, 5);
    endtask : t_unhalted
    // three hits, two misses held several cycles, one stray hit flag
    task automatic t_fetch(input logic [7:0] u0, input logic [7:0] u1, input int x0, input int x1);
        logic [2:0] vec [12] = '{3'h6, 3'h6, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h6,
            3'h2, 3'h0};
        cfg(EVT_IFETCH, u0, EVT_IFETCH, u1);
        foreach (vec[i]) begin
            @(posedge clock);
            {fetch_valid, fetch_hit, fetch_miss_pending} <= vec[i];
        end
        deltas(x0, x1, 0, 0);
    endtask : t_fetch
    // responses matching a only, b only, both, neither, and one not valid
    task automatic t_offcore();
        logic [16:0] vec [5] = '{17'h1_0001, 17'h1_0010, 17'h1_0011, 17'h1_0100, 17'h0_0001};
        cfg(EVT_OFFCORE, UMASK_01, EVT_OFFCORE, UMASK_02);
        foreach (vec[i]) begin
            @(posedge clock);
            {ofc_resp_valid, ofc_resp_attr} <= vec[i];
        end
        deltas(2, 2, 0, 0);
    endtask : t_offcore
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence, ending with a reset in mid-run while the core runs
    initial begin
        rst_n = 1'b0;
        evt_sel = 16'h0000;
        umask = 16'h0000;
        ofc_qual_a = 16'h000F;
        ofc_qual_b = 16'h00F0;
        idle();
        repeat (11) @(posedge clock);
        zero_all();
        @(posedge clock);
        rst_n <= 1'b1;
        t_reject();
        t_unhalted();
        t_fetch(UMASK_01, UMASK_02, 3, 2);
        t_fetch(UMASK_03, 8'h04, 5, 0);
        t_offcore();
        @(posedge clock);
        halted <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        zero_all();
        final_report();
    end
endmodule : testbench
